// *** rtl/fsr_receiver.sv ***
// Behaviour
// - five information intervals between start and stop
// - spacing start edge synchronises the sampling
// - marking stop interval closes each character
// - current is marking, no current is spacing
// - default stop lasts 1.42 units
// - option for one-unit stop interval
// - space after printable, suppressed for functions
// - line advance single or double, also local
// - code sequence triggers one special function
// - idle line marks; long spacing means open
// - letters/figures codes select persistent case
`include "fsr_defs.svh"
module fsr_receiver
    import fsr_pkg::*;
#(
    parameter int              UNIT_CYC  = `FSR_UNIT_CYC,
    parameter int              DEPTH     = 2,
    parameter int              SEQ_LEN   = 2,
    parameter logic [SEQ_LEN*5-1:0] SEQ_CODES = `FSR_SEQ_DEFAULT
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       line_current,   // 1 = current flows
    input  wire logic       stop_short,     // 1 = 7.0 unit framing
    input  wire logic       double_line,    // line advance by two
    input  wire logic       local_line_req, // local line advance
    input  wire logic       out_ready,
    output logic            out_valid,
    output logic [4:0]      out_code,
    output logic            out_upper,
    output logic            out_space,
    output logic            out_line,
    output logic            out_line_two,
    output logic            out_seq,
    output logic            local_line_adv,
    output logic            frame_err,
    output logic            overrun,
    output logic            open_line
);
    // ---------------------------------------------------------------
    // constants
    // ---------------------------------------------------------------
    localparam int TICK_CYC = UNIT_CYC / `FSR_OVS_N; // 16x oversample
    localparam int AW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int EW       = 10;                    // entry width

    // non-printing codes suppress the spacing advance
    function automatic logic fsr_nonprint(input logic [4:0] c);
        return (c == `FSR_CODE_LTRS) || (c == `FSR_CODE_FIGS) ||
               (c == `FSR_CODE_LF)   || (c == `FSR_CODE_CR)   ||
               (c == `FSR_CODE_BLANK);
    endfunction : fsr_nonprint

    // ---------------------------------------------------------------
    // receiver and decode state
    // ---------------------------------------------------------------
    fsr_state_t  st_q,   st_d;      // framing state
    logic [31:0] div_q,  div_d;     // oversample divider
    logic [4:0]  tck_q,  tck_d;     // ticks within interval
    logic [2:0]  bit_q,  bit_d;     // intelligence pulse index
    logic [4:0]  sh_q,   sh_d;      // captured pulses
    logic        prev_q, prev_d;    // line level one cycle ago
    logic [7:0]  spc_q,  spc_d;     // spacing run length in ticks
    logic        pend_q, pend_d;    // character awaiting buffer
    logic [4:0]  pcode_q, pcode_d;  // that character
    logic        upper_q, upper_d;  // figures case selected
    logic [3:0]  sidx_q, sidx_d;    // sequence progress
    logic        fe_q,   fe_d;
    logic        ov_q,   ov_d;
    logic        lla_q,  lla_d;
    logic        open_q, open_d;
    logic        tick;              // oversample enable
    logic        done;              // good character captured
    logic        push;              // pending word enters buffer
    logic        in_ready;          // buffer has room
    logic        seq_fire;          // sequence completed
    logic [4:0]  tail_last;         // last tick of stop remainder
    logic [EW-1:0] entry;           // word written to buffer

    assign tick      = (div_q == 32'(TICK_CYC - 1));
    assign tail_last = (stop_short ? `FSR_TAIL_SHORT
                                   : `FSR_TAIL_LONG) - 5'h01;
    assign push      = pend_q && in_ready;

    // next state of framing, decode and flags
    always_comb begin
        st_d    = st_q;
        div_d   = tick ? 32'h0 : div_q + 32'h1;
        tck_d   = tck_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        prev_d  = line_current;
        spc_d   = spc_q;
        pend_d  = pend_q;
        pcode_d = pcode_q;
        upper_d = upper_q;
        sidx_d  = sidx_q;
        fe_d    = 1'b0;
        ov_d    = 1'b0;
        lla_d   = local_line_req;
        done    = 1'b0;
        seq_fire = 1'b0;
        // spacing run, continuous spacing marks an open line
        if (line_current) begin
            spc_d = 8'h00;
        end else if (tick && spc_q != `FSR_OPEN_TICKS) begin
            spc_d = spc_q + 8'h01;
        end
        open_d = (spc_q == `FSR_OPEN_TICKS);
        unique case (st_q)
            FSR_IDLE: begin
                // mark to space edge opens a character
                if (prev_q && !line_current) begin
                    st_d  = FSR_START;
                    div_d = 32'h0;
                    tck_d = 5'h00;
                end
            end
            FSR_START: begin
                if (tick) begin
                    if (tck_q == `FSR_HALF_LAST) begin
                        // centre of start must still be spacing
                        st_d  = line_current ? FSR_IDLE : FSR_DATA;
                        tck_d = 5'h00;
                        bit_d = 3'h0;
                    end else begin
                        tck_d = tck_q + 5'h01;
                    end
                end
            end
            FSR_DATA: begin
                if (tick) begin
                    if (tck_q == `FSR_OVS_LAST) begin
                        // centre sample of one pulse
                        sh_d  = {line_current, sh_q[4:1]};
                        tck_d = 5'h00;
                        if (bit_q == `FSR_LAST_BIT) begin
                            st_d = FSR_STOP;
                        end else begin
                            bit_d = bit_q + 3'h1;
                        end
                    end else begin
                        tck_d = tck_q + 5'h01;
                    end
                end
            end
            FSR_STOP: begin
                if (tick) begin
                    if (tck_q == `FSR_OVS_LAST) begin
                        tck_d = 5'h00;
                        if (line_current) begin
                            st_d = FSR_TAIL;
                            done = 1'b1;
                        end else begin
                            st_d = FSR_IDLE;
                            fe_d = 1'b1;
                        end
                    end else begin
                        tck_d = tck_q + 5'h01;
                    end
                end
            end
            FSR_TAIL: begin
                // rest of the stop interval, length by framing
                if (tick) begin
                    if (tck_q == tail_last) begin
                        st_d = FSR_IDLE;
                    end else begin
                        tck_d = tck_q + 5'h01;
                    end
                end
            end
            default: begin
                st_d = FSR_IDLE;
            end
        endcase
        // sequence matcher and case shift on buffer entry
        if (push) begin
            pend_d = 1'b0;
            if (pcode_q == SEQ_CODES[sidx_q*5 +: 5]) begin
                if (sidx_q == 4'(SEQ_LEN - 1)) begin
                    seq_fire = 1'b1;
                    sidx_d   = 4'h0;
                end else begin
                    sidx_d = sidx_q + 4'h1;
                end
            end else if (pcode_q == SEQ_CODES[4:0]) begin
                sidx_d = (SEQ_LEN == 1) ? 4'h0 : 4'h1;
                seq_fire = (SEQ_LEN == 1);
            end else begin
                sidx_d = 4'h0;
            end
            if (pcode_q == `FSR_CODE_LTRS) begin
                upper_d = 1'b0;
            end else if (pcode_q == `FSR_CODE_FIGS) begin
                upper_d = 1'b1;
            end
        end
        // captured character waits for buffer room
        if (done) begin
            if (pend_q && !push) begin
                ov_d = 1'b1;
            end else begin
                pend_d  = 1'b1;
                pcode_d = sh_q;
            end
        end
    end

    assign entry = {pcode_q, upper_d,
                    !fsr_nonprint(pcode_q) && !seq_fire,
                    pcode_q == `FSR_CODE_LF,
                    double_line, seq_fire};

    // registers of framing, decode and flags
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q    <= FSR_IDLE;
            div_q   <= 32'h0;
            tck_q   <= 5'h00;
            bit_q   <= 3'h0;
            sh_q    <= 5'h00;
            prev_q  <= 1'b0;
            spc_q   <= 8'h00;
            pend_q  <= 1'b0;
            pcode_q <= 5'h00;
            upper_q <= 1'b0;
            sidx_q  <= 4'h0;
            fe_q    <= 1'b0;
            ov_q    <= 1'b0;
            lla_q   <= 1'b0;
            open_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            div_q   <= div_d;
            tck_q   <= tck_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            prev_q  <= prev_d;
            spc_q   <= spc_d;
            pend_q  <= pend_d;
            pcode_q <= pcode_d;
            upper_q <= upper_d;
            sidx_q  <= sidx_d;
            fe_q    <= fe_d;
            ov_q    <= ov_d;
            lla_q   <= lla_d;
            open_q  <= open_d;
        end
    end

    // ---------------------------------------------------------------
    // two-entry output buffer
    // ---------------------------------------------------------------
    logic [EW-1:0] mem_q [DEPTH];   // entries
    logic [EW-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d;      // write pointer
    logic [AW-1:0] rd_q, rd_d;      // read pointer
    logic [AW:0]   cnt_q, cnt_d;    // fill level
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign pop       = out_valid && out_ready;

    // next pointers and contents
    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = entry;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    // buffer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign {out_code, out_upper, out_space, out_line,
            out_line_two, out_seq} = mem_q[rd_q];
    assign local_line_adv = lla_q;
    assign frame_err      = fe_q;
    assign overrun        = ov_q;
    assign open_line      = open_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_START_EDGE: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_IDLE && st_d == FSR_START |-> prev_q && !line_current)
        else $error("start without mark to space edge");
    AST_START_CENTRE: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_START && st_d == FSR_DATA |-> !line_current)
        else $error("data entered on marking start");
    AST_FIVE_BITS: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_DATA && st_d == FSR_STOP |-> bit_q == 3'h4)
        else $error("stop reached after wrong pulse count");
    // a character that finds the pending slot free or being pushed is kept
    AST_STOP_MARK: assert property (@(posedge clock) disable iff (rst)
        done && (!pend_q || push)
        |-> line_current ##1 pend_q && pcode_q == $past(sh_q))
        else $error("character kept without marking stop");
    AST_OVR_DROP: assert property (@(posedge clock) disable iff (rst)
        done && pend_q && !push |=> overrun && $stable(pcode_q))
        else $error("overrun not flagged or pending word replaced");
    AST_FRAME_DROP: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_STOP && st_d == FSR_IDLE |=> frame_err && !$rose(pend_q))
        else $error("framing error not flagged or word kept");
    AST_TAIL_LEN: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_TAIL |-> tck_q <= (stop_short ? 5'h07 : 5'h0d))
        else $error("stop remainder too long");
    AST_SHORT_TAIL: assert property (@(posedge clock) disable iff (rst)
        st_q == FSR_TAIL && tick && tck_q == 5'h07 && stop_short
        |=> st_q == FSR_IDLE)
        else $error("short stop not honoured");
    AST_OPEN_LINE: assert property (@(posedge clock) disable iff (rst)
        open_line |-> $past(!line_current, 2))
        else $error("open line with current flowing");
    AST_SPACE_SUPP: assert property (@(posedge clock) disable iff (rst)
        out_valid && out_space |-> !fsr_nonprint(out_code) && !out_seq)
        else $error("space advance on function code");
    AST_LINE_CODE: assert property (@(posedge clock) disable iff (rst)
        out_valid && out_line |-> out_code == `FSR_CODE_LF)
        else $error("line advance on wrong code");
    AST_LOCAL_LINE: assert property (@(posedge clock) disable iff (rst)
        local_line_req |=> local_line_adv)
        else $error("local line request lost");
    AST_FIGS_CASE: assert property (@(posedge clock) disable iff (rst)
        push && pcode_q == `FSR_CODE_FIGS |=> upper_q [*2])
        else $error("figures case not held");
    AST_SEQ_SINGLE: assert property (@(posedge clock) disable iff (rst)
        seq_fire |=> sidx_q == 4'h0)
        else $error("sequence not restarted");
    AST_BUF_FULL: assert property (@(posedge clock) disable iff (rst)
        pend_q && !in_ready |=> pend_q && $stable(pcode_q))
        else $error("pending word lost under stall");
endmodule : fsr_receiver

// *** rtl/fsr_defs.svh ***
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FSR_CLK_MHZ       125
`define FSR_UNIT_US       22000
`define FSR_UNIT_CYC      (`FSR_UNIT_US * `FSR_CLK_MHZ)
`define FSR_OVS_N         16
`define FSR_OVS_LAST      5'h0f
`define FSR_HALF_LAST     5'h07
`define FSR_TAIL_LONG     5'h0e
`define FSR_TAIL_SHORT    5'h08
`define FSR_LAST_BIT      3'h4
`define FSR_OPEN_TICKS    8'h80
// ---------------------------------------------------------------
// codes, first intelligence pulse in bit 0, marking = 1
// ---------------------------------------------------------------
`define FSR_CODE_LTRS     5'h1f
`define FSR_CODE_FIGS     5'h1b
`define FSR_CODE_LF       5'h02
`define FSR_CODE_CR       5'h08
`define FSR_CODE_BLANK    5'h00
`define FSR_SEQ_DEFAULT   10'h01b
`endif

// *** rtl/fsr_pkg.sv ***
package fsr_pkg;
    // receiver sequencing states
    typedef enum logic [2:0] {
        FSR_IDLE  = 3'b000,
        FSR_START = 3'b001,
        FSR_DATA  = 3'b010,
        FSR_STOP  = 3'b011,
        FSR_TAIL  = 3'b100
    } fsr_state_t;
endpackage : fsr_pkg

// *** test/fsr_line_tx.sv ***
// ---------------------------------------------------------------
// far-side start-stop transmitter on the current loop
// ---------------------------------------------------------------
module fsr_line_tx #(
    parameter int UNIT = 160      // cycles per unit interval
) (
    input  wire logic clock,
    output logic      line_current // 1 = current flows
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle line stays marking between characters
    initial line_current = 1'b1;

    // drive a level for n cycles, changing just after an edge
    task automatic hold(input logic v, input int n);
        line_current = v;
        repeat (n) @(posedge clock);
        #1;
    endtask : hold

    // one character: spacing start, five pulses, marking stop
    task automatic send(input logic [4:0] code, input logic short_stop,
                        input logic bad_stop, input int gap);
        hold(1'b0, UNIT);
        // first intelligence pulse goes out first
        for (int i = 0; i < 5; i++) begin
            hold(code[i], UNIT);
        end
        // a broken stop only when the bench asks for one
        if (bad_stop) begin
            hold(1'b0, UNIT);
        end
        // stop of one unit or of 1.42 units, then optional idle
        if (short_stop) begin
            hold(1'b1, UNIT + gap);
        end else begin
            hold(1'b1, UNIT * 142 / 100 + gap);
        end
    endtask : send
endmodule : fsr_line_tx

// *** test/tb_fsr_receiver.sv ***
`include "fsr_defs.svh"
module tb_fsr_receiver;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // bench state
    // ---------------------------------------------------------------
    localparam int         UNIT = 160;  // short unit, tick of 10 cycles
    localparam logic [9:0] SEQ  = `FSR_SEQ_DEFAULT;
    typedef struct packed {
        logic [4:0] code;
        logic       upper;
        logic       space;
        logic       line;
        logic       two;
        logic       seq;
    } fsr_exp_t;
    logic        clock, rst, line_current, stop_short, double_line;
    logic        local_line_req, out_ready, out_valid, out_upper;
    logic        out_space, out_line, out_line_two, out_seq;
    logic        local_line_adv, frame_err, overrun, open_line;
    logic [4:0]  out_code;
    logic        hold_ready, prev_req, prev_rst, upper_m;
    logic [31:0] rnd;
    fsr_exp_t    exp_q[$];       // words still owed by the design
    fsr_exp_t    got;
    int          n_fail, cmp_count, n_fe, n_ov, exp_fe, exp_ov, seq_idx;
    logic [4:0]  tab[8] = '{5'h1b, 5'h05, 5'h00, 5'h1b,
                            5'h1b, 5'h00, 5'h1f, 5'h05};

    fsr_receiver #(.UNIT_CYC(UNIT)) dut (
        .clock(clock), .rst(rst), .line_current(line_current),
        .stop_short(stop_short), .double_line(double_line),
        .local_line_req(local_line_req), .out_ready(out_ready),
        .out_valid(out_valid), .out_code(out_code),
        .out_upper(out_upper), .out_space(out_space),
        .out_line(out_line), .out_line_two(out_line_two),
        .out_seq(out_seq), .local_line_adv(local_line_adv),
        .frame_err(frame_err), .overrun(overrun),
        .open_line(open_line));
    fsr_line_tx #(.UNIT(UNIT)) far (.clock(clock),
                                    .line_current(line_current));

    // xorshift source for ready and local requests
    function automatic logic [31:0] fsr_xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : fsr_xs

    // compare helper, counts and reports at once
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // model one character, then let the far side send it
    task automatic tx(input logic [4:0] c, input int mode, input int gap);
        fsr_exp_t e;
        if (mode == 0) begin
            if (c == `FSR_CODE_LTRS) upper_m = 1'b0;
            if (c == `FSR_CODE_FIGS) upper_m = 1'b1;
            e.seq = 1'b0;
            if (c == SEQ[seq_idx*5 +: 5]) seq_idx++;
            else seq_idx = (c == SEQ[4:0]) ? 1 : 0;
            if (seq_idx == 2) begin
                e.seq   = 1'b1;
                seq_idx = 0;
            end
            e.code  = c;
            e.upper = upper_m;
            e.line  = (c == `FSR_CODE_LF);
            e.two   = double_line;
            e.space = !e.seq && !(c inside {`FSR_CODE_LTRS, `FSR_CODE_FIGS,
                      `FSR_CODE_LF, `FSR_CODE_CR, `FSR_CODE_BLANK});
            exp_q.push_back(e);
        end
        if (mode == 1) exp_fe++;
        if (mode == 2) exp_ov++;
        far.send(c, stop_short, mode == 1, gap);
    endtask : tx

    // wait, bounded, until every owed word was popped
    task automatic drain();
        for (int i = 0; i < 4000 && exp_q.size() != 0; i++) begin
            @(posedge clock);
        end
        #1;
        check(exp_q.size() == 0, "words left in buffer");
        if (exp_q.size() != 0) close_out();
    endtask : drain

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // random ready and local requests, just after each edge
    always @(posedge clock) begin
        #1;
        rnd = fsr_xs(rnd);
        out_ready = hold_ready ? 1'b0 : rnd[0];
        local_line_req = rnd[7] & rnd[9] & !rst;
    end

    // ---------------------------------------------------------------
    // monitor: pops, pulses and the local advance
    // ---------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst && !prev_rst) begin
            check(local_line_adv === prev_req, "local advance");
            if (frame_err === 1'b1) n_fe++;
            if (overrun === 1'b1) n_ov++;
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check(1'b0, "word without character");
                end else begin
                    got = exp_q.pop_front();
                    check({out_code, out_upper, out_space, out_line,
                        out_line_two, out_seq} === got, "word");
                end
            end
        end
        prev_req = local_line_req;
        prev_rst = rst;
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rnd = 32'h0000000b;
        {rst, prev_rst} = 2'h3;
        {stop_short, double_line, out_ready} = 3'h0;
        {local_line_req, hold_ready, prev_req, upper_m} = 4'h0;
        {n_fail, cmp_count, n_fe, n_ov, exp_fe, exp_ov, seq_idx} = '0;
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        check(out_valid === 1'b0 && open_line === 1'b0, "reset");
        repeat (20) @(posedge clock);
        #1;
        // every code once in 7.42 unit framing
        for (int c = 0; c < 32; c++) begin
            double_line = rnd[3];
            tx(c[4:0], 0, 0);
        end
        // case shifts and the two-code function sequence
        foreach (tab[i]) begin
            tx(tab[i], 0, 0);
        end
        drain();
        // 7.0 unit framing with random codes
        stop_short = 1'b1;
        for (int i = 0; i < 12; i++) begin
            double_line = rnd[4];
            tx(rnd[12:8], 0, 4);
        end
        drain();
        stop_short = 1'b0;
        // consumer stalls: two words plus one pending, fourth lost
        hold_ready = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        tx(5'h05, 0, 0);
        tx(5'h06, 0, 0);
        tx(5'h07, 0, 0);
        tx(5'h03, 2, 0);
        check(n_ov == exp_ov, "overrun pulse");
        hold_ready = 1'b0;
        drain();
        // spacing stop, then a good character to show recovery
        tx(5'h0a, 1, 0);
        tx(5'h0b, 0, 0);
        // short spacing glitch must not start a character
        far.hold(1'b0, 3);
        far.hold(1'b1, 2 * UNIT);
        // open line: long spacing, also a failed stop
        exp_fe++;
        far.hold(1'b0, 1500);
        check(open_line === 1'b1, "open line");
        far.hold(1'b1, 2 * UNIT);
        check(open_line === 1'b0, "line closed");
        tx(5'h0c, 0, 0);
        drain();
        check(n_fe == exp_fe, "framing errors");
        check(n_ov == exp_ov, "overruns");
        check(out_valid === 1'b0, "buffer empty");
        close_out();
    end
endmodule : tb_fsr_receiver
